// ==== inc/prio_regen_regs.vh ====
// Register map, field layout and reset values of the priority regen bank
// Overview of operation
// R1 - Each regeneration table holds eight 3-bit fields, field n at bits 3n+2:3n.
// R2 - The queue priority of a frame is its regenerated priority, not its raw one.
// R3 - After reset each field equals its own index, giving an identity mapping.
// R4 - Ports 1 and 2 each remap only through their own writable table.
// R5 - Each of ports 0 to 2 counts unlearned or displaced source addresses.
// R6 - Reading a learn-discard counter returns its value and clears it.
// R7 - A learn-discard counter holds at all ones instead of wrapping.
// R8 - Mask bit 0 set blocks every switch interrupt source from the output.
// R9 - Mask bit 0 cleared lets any pending event raise the interrupt again.
// R10 - The mask gates only the output; pending bits still set and read back.
// R11 - The mask bit comes out of reset set.
// R12 - A packet drop sets the pending status bit that the mask gates.
// R13 - An increment coinciding with a clearing read restarts the count at one.
`ifndef PRIO_REGEN_REGS_VH
`define PRIO_REGEN_REGS_VH

`define ADDR_W 16
`define IDX_W 14
`define IDX_P1_REGEN 14'h1856
`define IDX_P2_REGEN 14'h1857
`define IDX_P0_LRN_CNT 14'h1858
`define IDX_P1_LRN_CNT 14'h1859
`define IDX_P2_LRN_CNT 14'h185A
`define IDX_IRQ_MASK 14'h1880
`define IDX_IRQ_PEND 14'h1881

`define PRIO_W 3
`define REGEN_W 24
`define REGEN_RESET 24'hFA_C688
`define CNT_W 32
`define CNT_RESET 32'h0000_0000
`define CNT_MAX 32'hFFFF_FFFF
`define MASK_BIT 0
`define MASK_RESET 1'h1
`define PEND_BIT 0

`endif

// ==== hw/prio_remap.v ====
// Regenerated priority lookup for one ingress port
`include "prio_regen_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module prio_remap (
  input wire clk,
  input wire rst_n,
  input wire [`REGEN_W-1:0] table_in,
  input wire rx_valid,
  input wire [`PRIO_W-1:0] rx_prio,
  output reg q_valid,
  output reg [`PRIO_W-1:0] q_prio
);
  function [`PRIO_W-1:0] field_of;
    input [`REGEN_W-1:0] tbl;
    input [`PRIO_W-1:0] idx;
    begin
      field_of = tbl[idx*`PRIO_W +: `PRIO_W]; // R1
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_valid <= 1'b0;
      q_prio <= 3'h0;
    end else begin
      q_valid <= rx_valid;
      if (rx_valid) begin
        q_prio <= field_of(table_in, rx_prio); // R2
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/sat_rc_counter.v ====
// Saturating counter cleared by a software read
`include "prio_regen_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sat_rc_counter #(
  parameter WIDTH = `CNT_W
) (
  input wire clk,
  input wire rst_n,
  input wire inc,
  input wire rd_clr,
  output reg [WIDTH-1:0] count
);
  wire at_max;

  assign at_max = &count;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (rd_clr) begin
      // Reader already took the old value; keep the coinciding event
      count <= {{(WIDTH-1){1'b0}}, inc}; // R6 R13
    end else if (inc && !at_max) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1}; // R5 R7
    end
  end
endmodule
`default_nettype wire

// ==== hw/prio_regen_learn_regs.v ====
// Priority regeneration tables, learn-discard counters and switch irq mask
//
// Strobed register access is this design's own decision.
`include "prio_regen_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module prio_regen_learn_regs (
  input wire CLK_SYS,
  input wire RESETN,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [31:0] WR_DATA,
  input wire WR_EN,
  input wire RD_EN,
  output reg [31:0] RD_DATA,
  input wire P1_RX_VALID,
  input wire [`PRIO_W-1:0] P1_RX_PRIO,
  output wire P1_Q_VALID,
  output wire [`PRIO_W-1:0] P1_Q_PRIO,
  input wire P2_RX_VALID,
  input wire [`PRIO_W-1:0] P2_RX_PRIO,
  output wire P2_Q_VALID,
  output wire [`PRIO_W-1:0] P2_Q_PRIO,
  input wire [2:0] LEARN_DISCARD,
  input wire PKT_DROP,
  output wire IRQ
);
  reg rst_meta_r;
  reg rst_n_r;
  reg [`REGEN_W-1:0] p1_regen_r;
  reg [`REGEN_W-1:0] p2_regen_r;
  reg mask_r;
  reg pend_r;
  reg [31:0] rd_nxt;
  wire [`CNT_W-1:0] cnt0;
  wire [`CNT_W-1:0] cnt1;
  wire [`CNT_W-1:0] cnt2;
  wire [`IDX_W-1:0] idx;
  wire on_word;
  wire rd_cnt0;
  wire rd_cnt1;
  wire rd_cnt2;
  wire rd_pend;

  // Release of the asynchronous reset is retimed to avoid recovery hazards
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Registers sit on aligned words; byte offsets inside a word miss
  assign idx = ADDR[`ADDR_W-1:2];
  assign on_word = (ADDR[1:0] == 2'h0);

  function hit;
    input [`IDX_W-1:0] a;
    input [`IDX_W-1:0] b;
    input aligned;
    begin
      hit = aligned && (a == b);
    end
  endfunction

  assign rd_cnt0 = RD_EN && hit(idx, `IDX_P0_LRN_CNT, on_word); // R6
  assign rd_cnt1 = RD_EN && hit(idx, `IDX_P1_LRN_CNT, on_word); // R6
  assign rd_cnt2 = RD_EN && hit(idx, `IDX_P2_LRN_CNT, on_word); // R6
  assign rd_pend = RD_EN && hit(idx, `IDX_IRQ_PEND, on_word);

  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      p1_regen_r <= `REGEN_RESET; // R3
      p2_regen_r <= `REGEN_RESET; // R3
      mask_r <= `MASK_RESET; // R11
    end else if (WR_EN) begin
      if (hit(idx, `IDX_P1_REGEN, on_word)) begin
        p1_regen_r <= WR_DATA[`REGEN_W-1:0]; // R4
      end
      if (hit(idx, `IDX_P2_REGEN, on_word)) begin
        p2_regen_r <= WR_DATA[`REGEN_W-1:0]; // R4
      end
      if (hit(idx, `IDX_IRQ_MASK, on_word)) begin
        mask_r <= WR_DATA[`MASK_BIT]; // R8 R9
      end
    end
  end

  // Drop event wins over a coinciding clearing read
  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_r <= 1'b0;
    end else if (PKT_DROP) begin
      pend_r <= 1'b1; // R12 R10
    end else if (rd_pend) begin
      pend_r <= 1'b0;
    end
  end

  assign IRQ = pend_r && !mask_r; // R8 R9 R10

  always @* begin
    rd_nxt = 32'h0000_0000;
    if (on_word) begin
      case (idx)
        `IDX_P1_REGEN: rd_nxt = {8'h00, p1_regen_r};
        `IDX_P2_REGEN: rd_nxt = {8'h00, p2_regen_r};
        `IDX_P0_LRN_CNT: rd_nxt = cnt0;
        `IDX_P1_LRN_CNT: rd_nxt = cnt1;
        `IDX_P2_LRN_CNT: rd_nxt = cnt2;
        `IDX_IRQ_MASK: rd_nxt = {31'h0000_0000, mask_r};
        `IDX_IRQ_PEND: rd_nxt = {31'h0000_0000, pend_r}; // R10
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      RD_DATA <= 32'h0000_0000;
    end else if (RD_EN) begin
      RD_DATA <= rd_nxt;
    end else begin
      RD_DATA <= 32'h0000_0000;
    end
  end

  sat_rc_counter #(.WIDTH(`CNT_W)) u_cnt0 (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .inc(LEARN_DISCARD[0]),
    .rd_clr(rd_cnt0),
    .count(cnt0)
  );

  sat_rc_counter #(.WIDTH(`CNT_W)) u_cnt1 (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .inc(LEARN_DISCARD[1]),
    .rd_clr(rd_cnt1),
    .count(cnt1)
  );

  sat_rc_counter #(.WIDTH(`CNT_W)) u_cnt2 (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .inc(LEARN_DISCARD[2]),
    .rd_clr(rd_cnt2),
    .count(cnt2)
  );

  // Each port looks up only its own table
  prio_remap u_p1 (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .table_in(p1_regen_r),
    .rx_valid(P1_RX_VALID),
    .rx_prio(P1_RX_PRIO),
    .q_valid(P1_Q_VALID),
    .q_prio(P1_Q_PRIO)
  ); // R4 R2

  prio_remap u_p2 (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .table_in(p2_regen_r),
    .rx_valid(P2_RX_VALID),
    .rx_prio(P2_RX_PRIO),
    .q_valid(P2_Q_VALID),
    .q_prio(P2_Q_PRIO)
  ); // R4 R2
endmodule
`default_nettype wire

// ==== tb/prio_regen_chk.sv ====
// Port-level assertions for the priority regen register bank
`include "prio_regen_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module prio_regen_chk (
  input wire CLK_SYS,
  input wire RESETN,
  input wire [`ADDR_W-1:0] ADDR,
  input wire WR_EN,
  input wire RD_EN,
  input wire [31:0] RD_DATA,
  input wire P1_RX_VALID,
  input wire P1_Q_VALID,
  input wire P2_RX_VALID,
  input wire P2_Q_VALID,
  input wire [2:0] LEARN_DISCARD,
  input wire PKT_DROP,
  input wire IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  wire rd_c0 = RD_EN && ADDR == {`IDX_P0_LRN_CNT, 2'b00};
  wire rd_pd = RD_EN && ADDR == {`IDX_IRQ_PEND, 2'b00};
  sequence quiet_rd;
    rd_c0 && !LEARN_DISCARD[0];
  endsequence
  sequence hit_rd;
    rd_c0 && LEARN_DISCARD[0];
  endsequence
  AST_Q1: assert property (P1_RX_VALID |=> P1_Q_VALID)
    else $error("port1 answer missing");
  AST_Q1_IDLE: assert property (!P1_RX_VALID |=> !P1_Q_VALID)
    else $error("port1 stray answer");
  AST_Q2: assert property (P2_RX_VALID |=> P2_Q_VALID)
    else $error("port2 answer missing");
  AST_CNT_CLR: assert property (quiet_rd ##1 rd_c0 |=> RD_DATA == 0)
    else $error("count not cleared by read");
  AST_CNT_HIT: assert property (hit_rd ##1 rd_c0 |=> RD_DATA == 1)
    else $error("coinciding increment lost");
  AST_DROP: assert property (PKT_DROP ##1 rd_pd |=> RD_DATA[0])
    else $error("drop not pending");
  AST_PD_CLR: assert property (rd_pd && !PKT_DROP |=> !IRQ)
    else $error("irq after pending cleared");
  AST_IRQ_SRC: assert property ($rose(IRQ) |-> $past(PKT_DROP) || $past(WR_EN))
    else $error("irq without cause");
endmodule
bind prio_regen_learn_regs prio_regen_chk prio_regen_chk_i (.*);
`default_nettype wire

// ==== tb/prio_regen_learn_regs_test.sv ====
// Register-level test of the priority regen register bank
`include "prio_regen_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module prio_regen_learn_regs_test;
  logic CLK_SYS = 0, RESETN = 0, WR_EN = 0, RD_EN = 0, PKT_DROP = 0;
  logic P1_RX_VALID = 0, P2_RX_VALID = 0;
  logic [2:0] P1_RX_PRIO = '0, P2_RX_PRIO = '0, LEARN_DISCARD = '0;
  logic [15:0] ADDR = '0;
  logic [31:0] WR_DATA = '0;
  wire [31:0] RD_DATA;
  wire [2:0] P1_Q_PRIO, P2_Q_PRIO;
  wire P1_Q_VALID, P2_Q_VALID, IRQ;
  int num_errors = 0, checked = 0;
  prio_regen_learn_regs prio_regen_learn_regs_i (.*);
  always #5 CLK_SYS = ~CLK_SYS;
  task bus(input logic w, r, input logic [15:0] a, input logic [31:0] d);
    WR_EN <= w;
    RD_EN <= r;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CLK_SYS);
    #1;
  endtask
  task idle;
    bus('0, '0, '0, '0);
  endtask
  task chk(input string n, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [13:0] i, input logic [31:0] d);
    bus(1'b1, 1'b0, {i, 2'b00}, d);
  endtask
  // Data stands only in the cycle after the strobe
  task rd(input logic [13:0] i, input logic [31:0] e);
    bus(1'b0, 1'b1, {i, 2'b00}, '0);
    chk($sformatf("reg %h", i), e, RD_DATA);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1;
    rd(`IDX_P1_REGEN, {8'h00, `REGEN_RESET});
    rd(`IDX_P2_REGEN, {8'h00, `REGEN_RESET});
    rd(`IDX_IRQ_MASK, 32'h0000_0001);
    rd(14'h0000, 32'h0000_0000);
    $display("reset values done");
    wr(`IDX_P1_REGEN, 32'hFF05_3977);
    rd(`IDX_P1_REGEN, 32'h0005_3977);
    for (int p = 0; p < 8; p++) begin
      P1_RX_VALID <= 1'b1;
      P2_RX_VALID <= 1'b1;
      P1_RX_PRIO <= p[2:0];
      P2_RX_PRIO <= p[2:0];
      idle;
      chk("port1 queue", {1'b1, 3'(7 - p)}, {P1_Q_VALID, P1_Q_PRIO});
      chk("port2 queue", {1'b1, 3'(p)}, {P2_Q_VALID, P2_Q_PRIO});
    end
    P1_RX_VALID <= 1'b0;
    P2_RX_VALID <= 1'b0;
    idle;
    chk("queue valid", '0, {P1_Q_VALID, P2_Q_VALID});
    $display("remap done");
    LEARN_DISCARD <= 3'b111;
    repeat (3) idle;
    LEARN_DISCARD <= 3'b010;
    idle;
    LEARN_DISCARD <= 3'b000;
    rd(`IDX_P1_LRN_CNT, 32'h0000_0004);
    rd(`IDX_P2_LRN_CNT, 32'h0000_0003);
    wr(`IDX_P1_LRN_CNT, 32'h1234_5678);
    rd(`IDX_P1_LRN_CNT, 32'h0000_0000);
    LEARN_DISCARD <= 3'b001;
    rd(`IDX_P0_LRN_CNT, 32'h0000_0003);
    LEARN_DISCARD <= 3'b000;
    rd(`IDX_P0_LRN_CNT, 32'h0000_0001);
    rd(`IDX_P0_LRN_CNT, 32'h0000_0000);
    $display("counters done");
    PKT_DROP <= 1'b1;
    idle;
    PKT_DROP <= 1'b0;
    idle;
    chk("irq masked", '0, IRQ);
    rd(`IDX_IRQ_PEND, 32'h0000_0001);
    PKT_DROP <= 1'b1;
    idle;
    PKT_DROP <= 1'b0;
    wr(`IDX_IRQ_MASK, 32'hFFFF_FFFE);
    chk("irq open", 32'h0000_0001, IRQ);
    rd(`IDX_IRQ_MASK, 32'h0000_0000);
    PKT_DROP <= 1'b1;
    idle;
    PKT_DROP <= 1'b0;
    rd(`IDX_IRQ_PEND, 32'h0000_0001);
    chk("irq cleared", '0, IRQ);
    wr(`IDX_IRQ_MASK, 32'h0000_0001);
    PKT_DROP <= 1'b1;
    idle;
    PKT_DROP <= 1'b0;
    idle;
    chk("irq remasked", '0, IRQ);
    $display("interrupt done");
    give_verdict;
  end
  // Whole run is near 52 cycles
  initial begin
    repeat (2000) @(posedge CLK_SYS);
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
